// File: rtl/cbtfsp_pkg.sv
// Purpose: Shared constants for command bus training with set-point switching
// Assumes: 25 MHz clock; both ends sample every link signal on clk_i
// Notes:   Counts assume a fixed 40 ns clock
// Contract
// [R1] Clock enable fall in training swaps set point
// [R2] Clock enable rise restores entry set point
// [R3] Alternate set point without termination stays off
// [R4] Unbonded termination pad never terminates
// [R5] Controller programs alternate set before entry
// [R6] Hold clock and command after enable falls
// [R7] First pattern waits entry delay
// [R8] Space patterns; only last echo valid
// [R9] Valid clock before raising chip select
// [R10] Valid clock after chip select
// [R11] Hold inputs two clocks before enable rises
// [R12] Echo outputs float shortly after exit
// [R13] Termination follows enable edge within 20 ns
// [R14] Wait exit delay before next command
// [R15] Exit class from reference value and range
// [R16] Power-up selects set point zero
// [R17] Controller selects writable set point one
// [R18] Trained reference rewritten after exit
// [R19] Enter by mode write, delay, enable low
// [R20] Exit by enable high, wait, mode write
// [R21] Latched CA echoed onto DQ
// [R22] Waits take larger of cycles and time
package cbtfsp_pkg;

   // ---------------------------------------------------------------
   // Widths and mode register layout
   // ---------------------------------------------------------------
   localparam int CA_W   = 6;
   localparam int MA_W   = 6;
   localparam int OP_W   = 8;
   localparam int VREF_W = 7;
   localparam int CNT_W  = 8;

   localparam logic [MA_W-1:0] MR_TERM  = 6'h0b;
   localparam logic [MA_W-1:0] MR_VREF  = 6'h0c;
   localparam logic [MA_W-1:0] MR_FSP   = 6'h0d;
   localparam int              TRAIN_BIT = 0;
   localparam int              WR_BIT    = 6;
   localparam int              OP_BIT    = 7;
   localparam int              TERM_LO   = 4;
   localparam int              TERM_HI   = 6;
   localparam int              RANGE_BIT = 6;
   localparam logic [5:0]      LONG_STEP = 6'h0c;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 40000;

   function automatic int imax(input int a, input int b);
      return (a > b) ? a : b;
   endfunction : imax

   // Least times round up, longest times round down, never below one
   function automatic int cyc_min(input int ps);
      return imax((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS, 1);
   endfunction : cyc_min

   function automatic int cyc_max(input int ps);
      return imax(ps / CLK_PERIOD_PS, 1);
   endfunction : cyc_max

   localparam int CKELCK_PS     = 7500;
   localparam int CKELCK_NCK    = 3;
   localparam int ECHO_PS       = 20000;
   localparam int FIRST_PAT_PS  = 250000;
   localparam int XP_PS         = 7500;
   localparam int XP_NCK        = 5;
   localparam int PRECS_NCK     = 2;
   localparam int PSTCS_PS      = 7500;
   localparam int PSTCS_NCK     = 5;
   localparam int CKEH_NCK      = 2;
   localparam int TRISTATE_PS   = 1500;
   localparam int TERM_PS       = 20000;
   localparam int EXIT_SHORT_PS = 200000;
   localparam int EXIT_LONG_PS  = 250000;
   localparam int EXIT_NCK      = 5;
   localparam int MRD_NCK       = 10;

   localparam logic [CNT_W-1:0] ECHO_CYC = CNT_W'(cyc_max(ECHO_PS));
   localparam logic [CNT_W-1:0] SPACING_CYC = CNT_W'(cyc_min(ECHO_PS));
   localparam logic [CNT_W-1:0] SPACE_CYC =
      CNT_W'(imax(int'(SPACING_CYC), int'(ECHO_CYC)) + 1);
   localparam logic [CNT_W-1:0] CKELCK_CYC =
      CNT_W'(imax(cyc_min(CKELCK_PS), CKELCK_NCK));
   localparam logic [CNT_W-1:0] PRECS_CYC =
      CNT_W'(PRECS_NCK + imax(cyc_min(XP_PS), XP_NCK));
   localparam logic [CNT_W-1:0] ENTRY_CYC = CNT_W'(imax(imax(int'(CKELCK_CYC),
      cyc_min(FIRST_PAT_PS)), int'(PRECS_CYC)));
   localparam logic [CNT_W-1:0] PSTCS_CYC =
      CNT_W'(imax(cyc_min(PSTCS_PS), PSTCS_NCK));
   localparam logic [CNT_W-1:0] LINGER_CYC =
      CNT_W'(imax(int'(PSTCS_CYC), CKEH_NCK));
   localparam logic [CNT_W-1:0] TRISTATE_CYC = CNT_W'(cyc_max(TRISTATE_PS));
   localparam logic [CNT_W-1:0] TERM_CYC = CNT_W'(cyc_max(TERM_PS));
   localparam logic [CNT_W-1:0] EXIT_SHORT_CYC =
      CNT_W'(imax(cyc_min(EXIT_SHORT_PS), EXIT_NCK));
   localparam logic [CNT_W-1:0] EXIT_LONG_CYC =
      CNT_W'(imax(cyc_min(EXIT_LONG_PS), EXIT_NCK));
   localparam logic [CNT_W-1:0] MRD_CYC = CNT_W'(MRD_NCK);

endpackage : cbtfsp_pkg

// File: rtl/cbtfsp_link_if.sv
// Purpose: Link between controller training engine and memory die
// Assumes: All signals change on clk_i rising edge
// Notes:   dq is driven only by the die; dq_oe high while it drives
`timescale 1ns/1ps
`default_nettype none
interface cbtfsp_link_if;
   logic                            cke;
   logic                            cs;
   logic [cbtfsp_pkg::CA_W-1:0]     ca;
   logic [cbtfsp_pkg::CA_W-1:0]     dq;
   logic                            dq_oe;
   logic                            mr_wr;
   logic [cbtfsp_pkg::MA_W-1:0]     mr_addr;
   logic [cbtfsp_pkg::OP_W-1:0]     mr_data;

   modport dev (input cke, cs, ca, mr_wr, mr_addr, mr_data, output dq, dq_oe);
   modport ctl (output cke, cs, ca, mr_wr, mr_addr, mr_data, input dq, dq_oe);
endinterface : cbtfsp_link_if
`default_nettype wire

// File: rtl/cbtfsp_wait.sv
// Purpose: Down counter for minimum waits
// Assumes: count_i at least one when loaded
// Notes:   done_o high once count_i edges have passed since load
`timescale 1ns/1ps
`default_nettype none
module cbtfsp_wait (
   input  wire logic                        clk_i,
   input  wire logic                        resetn_i,
   input  wire logic                        load_i,
   input  wire logic [cbtfsp_pkg::CNT_W-1:0] count_i,
   output logic                             done_o
);
   typedef struct packed {
      logic [cbtfsp_pkg::CNT_W-1:0] cnt;
   } cbtfsp_wait_t;

   cbtfsp_wait_t s;
   cbtfsp_wait_t next_s;

   always_comb begin
      next_s = s;
      if (load_i) begin
         next_s.cnt = count_i;
      end else if (s.cnt != '0) begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done_o = (s.cnt == '0);
endmodule : cbtfsp_wait
`default_nettype wire

// File: rtl/cbtfsp_die.sv
// Purpose: Memory die end of command bus training (mode 1)
// Assumes: Link signals synchronous to clk_i
// Notes:   Mode writes are ignored while training is active
`timescale 1ns/1ps
`default_nettype none
module cbtfsp_die (
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   cbtfsp_link_if.dev                        link,
   input  wire logic                         term_pad_i,
   output logic                              setpoint_o,
   output logic                              ca_term_o,
   output logic                              training_o,
   output logic [cbtfsp_pkg::VREF_W-1:0]     vref_o
);
   typedef struct packed {
      logic                                    cke_q;
      logic                                    operating_setpoint_select;
      logic                                    writable_setpoint_select;
      logic                                    train;
      logic                                    in_cbt;
      logic                                    entry_op;
      logic [1:0][cbtfsp_pkg::VREF_W-1:0]      vref;
      logic [1:0]                              term_en;
      logic [cbtfsp_pkg::CA_W-1:0]             latch;
      logic [cbtfsp_pkg::CNT_W-1:0]            cnt;
      logic [cbtfsp_pkg::CA_W-1:0]             dq;
      logic                                    dq_oe;
      logic                                    term_on;
      logic [cbtfsp_pkg::VREF_W-1:0]           vref_out;
   } cbtfsp_die_t;

   cbtfsp_die_t s;
   cbtfsp_die_t next_s;
   logic        cke_fall;
   logic        cke_rise;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s   = s;
      cke_fall = s.cke_q & ~link.cke;
      cke_rise = ~s.cke_q & link.cke;
      next_s.cke_q = link.cke;
      if (link.mr_wr && !s.in_cbt) begin
         if (link.mr_addr == cbtfsp_pkg::MR_FSP) begin
            next_s.train  = link.mr_data[cbtfsp_pkg::TRAIN_BIT];
            next_s.writable_setpoint_select = link.mr_data[cbtfsp_pkg::WR_BIT];
            next_s.operating_setpoint_select = link.mr_data[cbtfsp_pkg::OP_BIT];
         end else if (link.mr_addr == cbtfsp_pkg::MR_VREF) begin
            next_s.vref[s.writable_setpoint_select] = link.mr_data[cbtfsp_pkg::VREF_W-1:0];
         end else if (link.mr_addr == cbtfsp_pkg::MR_TERM) begin
            next_s.term_en[s.writable_setpoint_select] =
               |link.mr_data[cbtfsp_pkg::TERM_HI:cbtfsp_pkg::TERM_LO];
         end
      end
      // Training never touches vref, so trained values are not kept; see [R18]
      if (s.in_cbt && link.cs) begin
         next_s.latch = link.ca;                  // see [R21]
         next_s.cnt   = cbtfsp_pkg::ECHO_CYC;     // see [R8]
      end else if (s.cnt == 8'h01) begin
         next_s.dq    = s.latch;                  // see [R21]
         next_s.dq_oe = 1'b1;
         next_s.cnt   = '0;
      end else if (s.cnt != '0) begin
         next_s.cnt = s.cnt - 1'b1;
      end
      if (s.train && !s.in_cbt && cke_fall) begin
         next_s.in_cbt   = 1'b1;
         next_s.entry_op = s.operating_setpoint_select;
         next_s.operating_setpoint_select   = ~s.operating_setpoint_select;             // see [R1]
      end
      if (s.in_cbt && cke_rise) begin
         next_s.in_cbt = 1'b0;
         next_s.operating_setpoint_select = s.entry_op;              // see [R2]
         next_s.dq_oe  = 1'b0;                    // see [R12]
         next_s.cnt    = '0;
      end
      // Follows the set point in the same edge, well inside the latency
      next_s.term_on = term_pad_i & next_s.term_en[next_s.operating_setpoint_select]; // see [R3] see [R4] see [R13]
      next_s.vref_out = next_s.vref[next_s.operating_setpoint_select];
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s       <= '0;                           // see [R16]
         s.cke_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign link.dq    = s.dq;
   assign link.dq_oe = s.dq_oe;
   assign setpoint_o = s.operating_setpoint_select;
   assign ca_term_o  = s.term_on;
   assign training_o = s.in_cbt;
   assign vref_o     = s.vref_out;
endmodule : cbtfsp_die
`default_nettype wire

// File: rtl/cbtfsp_ctl.sv
// Purpose: Controller training engine for command bus training (mode 1)
// Assumes: Clock runs continuously at the training rate
// Notes:   Each mode write is one strobe cycle carrying address and data
`timescale 1ns/1ps
`default_nettype none
module cbtfsp_ctl (
   input  wire logic                         clk_i,
   input  wire logic                         resetn_i,
   cbtfsp_link_if.ctl                        link,
   input  wire logic                         start_i,
   input  wire logic [2:0]                   term_code_i,
   input  wire logic [cbtfsp_pkg::VREF_W-1:0] vref_base_i,
   input  wire logic [cbtfsp_pkg::VREF_W-1:0] vref_train_i,
   input  wire logic [cbtfsp_pkg::VREF_W-1:0] trained_vref_i,
   input  wire logic                         pattern_valid_i,
   input  wire logic [cbtfsp_pkg::CA_W-1:0]   pattern_i,
   input  wire logic                         finish_i,
   output logic                              pattern_ready_o,
   output logic [cbtfsp_pkg::CA_W-1:0]       echo_o,
   output logic                              echo_valid_o,
   output logic                              busy_o,
   output logic                              done_o
);
   typedef enum {
      ST_IDLE,
      ST_PROG_TERM,
      ST_PROG_VREF,
      ST_ENTER,
      ST_WAIT_MRD,
      ST_SETTLE,
      ST_READY,
      ST_ECHO,
      ST_LINGER,
      ST_EXIT_WAIT,
      ST_STORE
   } cbtfsp_state_t;

   typedef struct packed {
      cbtfsp_state_t                   st;
      logic                            cke;
      logic                            cs;
      logic [cbtfsp_pkg::CA_W-1:0]     ca;
      logic                            mr_wr;
      logic [cbtfsp_pkg::MA_W-1:0]     mr_addr;
      logic [cbtfsp_pkg::OP_W-1:0]     mr_data;
      logic                            ready;
      logic [cbtfsp_pkg::CA_W-1:0]     echo;
      logic                            echo_valid;
      logic                            busy;
      logic                            done;
   } cbtfsp_ctl_t;

   cbtfsp_ctl_t                  s;
   cbtfsp_ctl_t                  next_s;
   logic                         t_load;
   logic [cbtfsp_pkg::CNT_W-1:0] t_count;
   logic                         t_done;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Range change or a large step needs the longer settling
   function automatic logic exit_is_long(
      input logic [cbtfsp_pkg::VREF_W-1:0] a,
      input logic [cbtfsp_pkg::VREF_W-1:0] b
   );
      logic [5:0] d;
      d = (a[5:0] > b[5:0]) ? (a[5:0] - b[5:0]) : (b[5:0] - a[5:0]);
      return (a[cbtfsp_pkg::RANGE_BIT] != b[cbtfsp_pkg::RANGE_BIT]) ||
             (d > cbtfsp_pkg::LONG_STEP);
   endfunction : exit_is_long

   function automatic logic [cbtfsp_pkg::OP_W-1:0] fsp_word(
      input logic train
   );
      logic [cbtfsp_pkg::OP_W-1:0] w;
      w = '0;
      w[cbtfsp_pkg::TRAIN_BIT] = train;
      w[cbtfsp_pkg::WR_BIT]    = 1'b1;
      return w;
   endfunction : fsp_word

   cbtfsp_wait u_wait (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .load_i   (t_load),
      .count_i  (t_count),
      .done_o   (t_done)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_s            = s;
      t_load            = 1'b0;
      t_count           = '0;
      next_s.mr_wr      = 1'b0;
      next_s.cs         = 1'b0;
      next_s.echo_valid = 1'b0;
      next_s.done       = 1'b0;
      case (s.st)
         ST_IDLE: begin
            if (start_i) begin
               next_s.busy    = 1'b1;
               next_s.mr_wr   = 1'b1;
               next_s.mr_addr = cbtfsp_pkg::MR_FSP;
               next_s.mr_data = fsp_word(1'b0);         // see [R17]
               next_s.st      = ST_PROG_TERM;
            end
         end
         ST_PROG_TERM: begin
            next_s.mr_wr   = 1'b1;
            next_s.mr_addr = cbtfsp_pkg::MR_TERM;
            next_s.mr_data = '0;
            next_s.mr_data[cbtfsp_pkg::TERM_HI:cbtfsp_pkg::TERM_LO] = term_code_i; // see [R5]
            next_s.st      = ST_PROG_VREF;
         end
         ST_PROG_VREF: begin
            next_s.mr_wr   = 1'b1;
            next_s.mr_addr = cbtfsp_pkg::MR_VREF;
            next_s.mr_data = {1'b0, vref_train_i};      // see [R5]
            next_s.st      = ST_ENTER;
         end
         ST_ENTER: begin
            next_s.mr_wr   = 1'b1;
            next_s.mr_addr = cbtfsp_pkg::MR_FSP;
            next_s.mr_data = fsp_word(1'b1);            // see [R19]
            t_load         = 1'b1;
            t_count        = cbtfsp_pkg::MRD_CYC;
            next_s.st      = ST_WAIT_MRD;
         end
         ST_WAIT_MRD: begin
            if (t_done) begin
               next_s.cke = 1'b0;                       // see [R19]
               t_load     = 1'b1;
               t_count    = cbtfsp_pkg::ENTRY_CYC;      // see [R6] see [R7] see [R9] see [R22]
               next_s.st  = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (t_done) begin
               next_s.ready = 1'b1;
               next_s.st    = ST_READY;
            end
         end
         ST_READY: begin
            if (pattern_valid_i) begin
               next_s.cs    = 1'b1;
               next_s.ca    = pattern_i;
               next_s.ready = 1'b0;
               t_load       = 1'b1;
               t_count      = cbtfsp_pkg::SPACE_CYC;    // see [R8]
               next_s.st    = ST_ECHO;
            end else if (finish_i) begin
               next_s.ready = 1'b0;
               t_load       = 1'b1;
               t_count      = cbtfsp_pkg::LINGER_CYC;   // see [R10] see [R11]
               next_s.st    = ST_LINGER;
            end
         end
         ST_ECHO: begin
            if (t_done) begin
               next_s.echo       = link.dq;
               next_s.echo_valid = link.dq_oe;
               next_s.ready      = 1'b1;
               next_s.st         = ST_READY;
            end
         end
         ST_LINGER: begin
            if (t_done) begin
               next_s.cke = 1'b1;                       // see [R20]
               t_load     = 1'b1;
               t_count    = exit_is_long(vref_base_i, trained_vref_i) ?
                            cbtfsp_pkg::EXIT_LONG_CYC :
                            cbtfsp_pkg::EXIT_SHORT_CYC; // see [R14] see [R15]
               next_s.st  = ST_EXIT_WAIT;
            end
         end
         ST_EXIT_WAIT: begin
            if (t_done) begin
               next_s.mr_wr   = 1'b1;
               next_s.mr_addr = cbtfsp_pkg::MR_FSP;
               next_s.mr_data = fsp_word(1'b0);         // see [R20]
               next_s.st      = ST_STORE;
            end
         end
         ST_STORE: begin
            next_s.mr_wr   = 1'b1;
            next_s.mr_addr = cbtfsp_pkg::MR_VREF;
            next_s.mr_data = {1'b0, trained_vref_i};    // see [R18]
            next_s.busy    = 1'b0;
            next_s.done    = 1'b1;
            next_s.st      = ST_IDLE;
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s     <= '0;
         s.st  <= ST_IDLE;
         s.cke <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign link.cke        = s.cke;
   assign link.cs         = s.cs;
   assign link.ca         = s.ca;
   assign link.mr_wr      = s.mr_wr;
   assign link.mr_addr    = s.mr_addr;
   assign link.mr_data    = s.mr_data;
   assign pattern_ready_o = s.ready;
   assign echo_o          = s.echo;
   assign echo_valid_o    = s.echo_valid;
   assign busy_o          = s.busy;
   assign done_o          = s.done;
endmodule : cbtfsp_ctl
`default_nettype wire

// File: dv/cbtfsp_monitor.sv
// Purpose: Wire-side timing checks for command bus training
// Assumes: Every link signal is sampled on the clk_i rising edge
// Notes:   Die outputs off the link are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module cbtfsp_monitor (
   input  wire logic                        clk_i,
   input  wire logic                        resetn_i,
   input  wire logic                        cke,
   input  wire logic                        cs,
   input  wire logic [cbtfsp_pkg::CA_W-1:0] ca,
   input  wire logic [cbtfsp_pkg::CA_W-1:0] dq,
   input  wire logic                        dq_oe,
   input  wire logic                        mr_wr,
   input  wire logic [cbtfsp_pkg::MA_W-1:0] mr_addr,
   input  wire logic [cbtfsp_pkg::OP_W-1:0] mr_data
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   sequence s_train_on;
      mr_wr && mr_addr == cbtfsp_pkg::MR_FSP && mr_data[cbtfsp_pkg::TRAIN_BIT];
   endsequence
   sequence s_train_off;
      mr_wr && mr_addr == cbtfsp_pkg::MR_FSP && !mr_data[cbtfsp_pkg::TRAIN_BIT];
   endsequence
   // Echo lands two edges after the pattern, select low meanwhile
   sequence s_echo;
      !cs ##1 (dq_oe && dq == $past(ca, 2));
   endsequence

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_entry_order;
      s_train_on |=> cke[*8] ##1 cke ##[1:12] !cke;
   endproperty
   property p_hold_low;
      $fell(cke) |-> ($stable(ca) && !cs && !mr_wr)[*3];
   endproperty
   property p_first_pat;
      $fell(cke) |-> !cs[*7];
   endproperty
   property p_spacing;
      cs |=> !cs[*2];
   endproperty
   property p_echo;
      cs && !cke |=> s_echo;
   endproperty
   property p_after_cs;
      cs |=> !cke[*5];
   endproperty
   property p_before_high;
      $rose(cke) |-> !$past(cs, 1) && !$past(cs, 2);
   endproperty
   property p_exit_wait;
      $rose(cke) |-> !mr_wr[*5] ##[1:6] s_train_off;
   endproperty
   property p_float;
      cke |=> !dq_oe;
   endproperty

   a_entry_order: assert property (p_entry_order) else $error("enable fell early");
   a_hold_low: assert property (p_hold_low) else $error("inputs moved in hold");
   a_first_pat: assert property (p_first_pat) else $error("pattern too early");
   a_spacing: assert property (p_spacing) else $error("patterns too close");
   a_echo: assert property (p_echo) else $error("echo wrong or late");
   a_after_cs: assert property (p_after_cs) else $error("enable rose after select");
   a_before_high: assert property (p_before_high) else $error("select near exit");
   a_exit_wait: assert property (p_exit_wait) else $error("exit write timing");
   a_float: assert property (p_float) else $error("echo driven outside training");
endmodule : cbtfsp_monitor
`default_nettype wire

// File: dv/tb.sv
// Purpose: Self-checking bench joining controller and die ends
// Assumes: Expected values come from the hand-over walk only
// Notes:   Driver queues expectations; a watcher pops them per result
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                            clk_i, resetn_i, start_i, finish_i, term_pad_i;
   logic                            pattern_valid_i, pattern_ready_o, echo_valid_o;
   logic                            busy_o, done_o, setpoint_o, ca_term_o, training_o;
   logic                            prev_training = 1'b0;
   logic [2:0]                      term_code_i;
   logic [cbtfsp_pkg::VREF_W-1:0]   vref_base_i, vref_train_i, trained_vref_i, vref_o;
   logic [cbtfsp_pkg::CA_W-1:0]     pattern_i, echo_o;
   logic [cbtfsp_pkg::CA_W-1:0]     echo_q[$];
   logic [9:0]                      state_q[$];
   logic [31:0]                     seed = 32'h0000005f;
   int                              errors = 0;
   int                              compares = 0;
   int                              cycles = 0;

   cbtfsp_link_if link ();
   cbtfsp_die i_cbtfsp_die (.clk_i(clk_i), .resetn_i(resetn_i), .link(link.dev),
      .term_pad_i(term_pad_i), .setpoint_o(setpoint_o), .ca_term_o(ca_term_o),
      .training_o(training_o), .vref_o(vref_o));
   cbtfsp_ctl i_cbtfsp_ctl (.clk_i(clk_i), .resetn_i(resetn_i), .link(link.ctl),
      .start_i(start_i), .term_code_i(term_code_i), .vref_base_i(vref_base_i),
      .vref_train_i(vref_train_i), .trained_vref_i(trained_vref_i),
      .pattern_valid_i(pattern_valid_i), .pattern_i(pattern_i), .finish_i(finish_i),
      .pattern_ready_o(pattern_ready_o), .echo_o(echo_o), .echo_valid_o(echo_valid_o),
      .busy_o(busy_o), .done_o(done_o));
   cbtfsp_monitor i_cbtfsp_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .cke(link.cke),
      .cs(link.cs), .ca(link.ca), .dq(link.dq), .dq_oe(link.dq_oe), .mr_wr(link.mr_wr),
      .mr_addr(link.mr_addr), .mr_data(link.mr_data));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic fail(input string msg);
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : fail

   task automatic cmp_echo(input logic [cbtfsp_pkg::CA_W-1:0] exp);
      compares++;
      if (echo_o !== exp) fail("echo value differs");
   endtask : cmp_echo

   task automatic cmp_state(input logic [9:0] exp);
      compares++;
      if ({setpoint_o, ca_term_o, training_o, vref_o} !== exp) fail("die state differs");
   endtask : cmp_state

   task automatic cmp_busy(input logic exp);
      compares++;
      if (busy_o !== exp) fail("busy differs");
   endtask : cmp_busy

   task automatic close_out();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   // Pattern is held until the edge that sees ready high
   task automatic send_pat(input logic [cbtfsp_pkg::CA_W-1:0] p);
      int n;
      @(negedge clk_i);
      pattern_valid_i = 1'b1;
      pattern_i = p;
      n = 0;
      while (pattern_ready_o !== 1'b1 && n < 300) begin
         @(negedge clk_i);
         n++;
      end
      @(posedge clk_i);
      if (n >= 300) fail("pattern not taken");
      else echo_q.push_back(p);
   endtask : send_pat

   // ---------------------------------------------------------------
   // Clock, watcher, timeout
   // ---------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(negedge clk_i) begin
      if (resetn_i === 1'b1) begin
         if (echo_valid_o === 1'b1) begin
            if (echo_q.size() == 0) fail("echo without pattern");
            else cmp_echo(echo_q.pop_front());
         end
         if (training_o === 1'b1 && prev_training === 1'b0) begin
            if (state_q.size() == 0) fail("training without start");
            else cmp_state(state_q.pop_front());
         end
         if (done_o === 1'b1) begin
            if (state_q.size() == 0) fail("done without start");
            else cmp_state(state_q.pop_front());
            cmp_busy(1'b0);
         end
      end
      prev_training = training_o;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail("timeout");
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      logic term;
      {start_i, finish_i, pattern_valid_i, term_pad_i, term_code_i} = '0;
      {vref_base_i, vref_train_i, trained_vref_i, pattern_i} = '0;
      resetn_i = 1'b0;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      resetn_i = 1'b1;
      @(negedge clk_i);
      cmp_state(10'h000);
      for (int r = 0; r < 4; r++) begin
         @(negedge clk_i);
         // Runs 1 and 2: unbonded pad, then disabled alternate termination
         term_pad_i = (r != 1);
         term_code_i = (r == 2) ? 3'h0 : 3'(xs() | 32'h1);
         vref_base_i = 7'(xs());
         vref_train_i = 7'(xs());
         trained_vref_i = 7'(xs());
         term = term_pad_i & (term_code_i != 3'h0);
         state_q.push_back({1'b1, term, 1'b1, vref_train_i});
         start_i = 1'b1;
         @(negedge clk_i);
         start_i = 1'b0;
         for (int k = 0; k < 3; k++) send_pat((r == 3) ? {6{k[0]}} : 6'(xs()));
         // Start while busy must be ignored
         @(negedge clk_i);
         pattern_valid_i = 1'b0;
         start_i = 1'b1;
         cmp_busy(1'b1);
         @(negedge clk_i);
         start_i = 1'b0;
         finish_i = 1'b1;
         state_q.push_back(10'h000);
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (done_o !== 1'b1 && n < 400);
         if (n >= 400) fail("done missing");
         @(negedge clk_i);
         finish_i = 1'b0;
         repeat (3) @(negedge clk_i);
         $display("run %0d finished", r);
      end
      close_out();
   end
endmodule : tb
`default_nettype wire
